/* File: rtl/tc8_timer.sv */
// 8-bit timer/counter with compare units, output latches and pin override
`timescale 1ns/10ps
`default_nettype none
module tc8_timer
   import tc8_pkg::*;
(
   // system clock and controls
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic timer_tick,
   input wire logic [2:0] waveform_mode_select,
   input wire logic [1:0] output_action_select_a,
   input wire logic [1:0] output_action_select_b,
   // counter write
   input wire logic count_wr,
   input wire logic [7:0] count_wdata,
   // compare value writes
   input wire logic compare_a_wr,
   input wire logic [7:0] compare_a_wdata,
   input wire logic compare_b_wr,
   input wire logic [7:0] compare_b_wdata,
   // force strobes
   input wire logic force_compare_strobe_a,
   input wire logic force_compare_strobe_b,
   // flag clears (software write of one or interrupt execution)
   input wire logic overflow_flag_clear,
   input wire logic compare_flag_a_clear,
   input wire logic compare_flag_b_clear,
   // general port values and direction bits
   input wire logic port_value_a,
   input wire logic port_value_b,
   input wire logic pin_direction_bit_a,
   input wire logic pin_direction_bit_b,
   // state read back
   output logic [7:0] count_value,
   output logic [7:0] compare_value_a,
   output logic [7:0] compare_value_b,
   output logic [7:0] compare_buffer_a,
   output logic [7:0] compare_buffer_b,
   output logic overflow_flag,
   output logic compare_flag_a,
   output logic compare_flag_b,
   output logic compare_output_latch_a,
   output logic compare_output_latch_b,
   // port pins
   output logic pin_out_a,
   output logic pin_oe_n_a,
   output logic pin_out_b,
   output logic pin_oe_n_b
);
   import tc8_pkg::*;

   tc8_state_t state_reg;
   tc8_state_t state_next;

   // per-channel views of the separate ports
   logic [NUM_CH-1:0][1:0] action;
   logic [NUM_CH-1:0] force_strobe;
   logic [NUM_CH-1:0] flag_clear;
   logic [NUM_CH-1:0] cmp_wr;
   logic [NUM_CH-1:0][7:0] cmp_wdata;
   logic [NUM_CH-1:0] port_value;
   logic [NUM_CH-1:0] dir_out;

   // decoded mode and events
   logic pwm;
   logic top_is_cmp_a;
   logic [7:0] top_value;
   logic step;
   logic at_top;
   logic at_max;
   logic cnt_clear;
   logic ovf_set;
   logic bottom;
   logic [7:0] cnt_inc;
   logic [NUM_CH-1:0] match;
   logic [NUM_CH-1:0] force_cmp;
   logic [NUM_CH-1:0] toggle_ok;
   logic [NUM_CH-1:0] latch_next;
   logic [NUM_CH-1:0] pin_out;
   logic [NUM_CH-1:0] pin_oe_n;

   // gather channel ports into arrays
   assign action[CH_A] = output_action_select_a;
   assign action[CH_B] = output_action_select_b;
   assign force_strobe[CH_A] = force_compare_strobe_a;
   assign force_strobe[CH_B] = force_compare_strobe_b;
   assign flag_clear[CH_A] = compare_flag_a_clear;
   assign flag_clear[CH_B] = compare_flag_b_clear;
   assign cmp_wr[CH_A] = compare_a_wr;
   assign cmp_wr[CH_B] = compare_b_wr;
   assign cmp_wdata[CH_A] = compare_a_wdata;
   assign cmp_wdata[CH_B] = compare_b_wdata;
   assign port_value[CH_A] = port_value_a;
   assign port_value[CH_B] = port_value_b;
   assign dir_out[CH_A] = pin_direction_bit_a;
   assign dir_out[CH_B] = pin_direction_bit_b;

   // mode decode; the output action never enters here
   assign pwm = (waveform_mode_select == MODE_FPWM_MAX) ||
                (waveform_mode_select == MODE_FPWM_CMPA);
   assign top_is_cmp_a = (waveform_mode_select == MODE_CTC) ||
                         (waveform_mode_select == MODE_FPWM_CMPA);
   assign top_value = top_is_cmp_a ? state_reg.cmp[CH_A] : CNT_MAX;

   // a timer tick only counts when the whole block is enabled
   assign step = ce && timer_tick;
   assign at_top = (state_reg.cnt == top_value);
   assign at_max = (state_reg.cnt == CNT_MAX);
   assign cnt_inc = state_reg.cnt + CNT_ONE;

   // in normal mode top is max, so clearing equals the natural wrap;
   // a compare A below the count in mode 2 is passed, count runs to max
   // outside pwm the clear is a compare match, so a counter write blocks it
   assign cnt_clear = step && at_top && (pwm || !state_reg.blk);

   // overflow: max to zero outside PWM, each top in fast PWM
   assign ovf_set = step && (pwm ? at_top : at_max);

   // fast PWM bottom event: the tick in which top rolls to bottom
   assign bottom = pwm && cnt_clear;

   // matches, forced compares and toggle permission per channel
   generate
      for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
         // equality seen at a tick, held off right after a counter write
         assign match[i] = step && !state_reg.blk &&
                           (state_reg.cnt == state_reg.cmp[i]);
         // force only means something outside PWM
         assign force_cmp[i] = ce && force_strobe[i] && !pwm;
         // in fast PWM toggling is only offered to channel A with top A
         assign toggle_ok[i] = !pwm ||
            ((i == CH_A) && (waveform_mode_select == MODE_FPWM_CMPA));

         tc8_out_chan u_chan (
            .action(action[i]),
            .pwm(pwm),
            .toggle_ok(toggle_ok[i]),
            .match(match[i]),
            .bottom(bottom),
            .force_cmp(force_cmp[i]),
            .latch(state_reg.latch[i]),
            .port_value(port_value[i]),
            .dir_out(dir_out[i]),
            .latch_next(latch_next[i]),
            .pin_out(pin_out[i]),
            .pin_oe_n(pin_oe_n[i])
         );
      end
   endgenerate

   // next-state logic for counter, compare registers and flags
   always_comb begin
      state_next = state_reg;

      // counting; a tick with no clear just increments
      if (cnt_clear) begin
         state_next.cnt = CNT_BOTTOM;
      end else if (step) begin
         state_next.cnt = cnt_inc;
      end

      // the blocking window lasts until the next timer tick
      if (step) begin
         state_next.blk = 1'b0;
      end

      // software counter write overrides any count or clear, even when
      // stopped; the block flag hides the written value from compare
      if (ce && count_wr) begin
         state_next.cnt = count_wdata;
         state_next.blk = 1'b1;
      end

      // overflow flag: clear first so a coincident set is kept
      if (ce && overflow_flag_clear) begin
         state_next.ovf = 1'b0;
      end
      if (ovf_set) begin
         state_next.ovf = 1'b1;
      end

      for (int i = 0; i < NUM_CH; i++) begin
         // compare writes: buffered in PWM, direct otherwise
         if (ce && cmp_wr[i]) begin
            state_next.cmp_buf[i] = cmp_wdata[i];
            if (!pwm) begin
               state_next.cmp[i] = cmp_wdata[i];
            end
         end
         // buffer reaches the comparator only at top-to-bottom
         if (bottom) begin
            state_next.cmp[i] = state_reg.cmp_buf[i];
         end

         // compare flag: set wins over clear; force never sets it
         if (ce && flag_clear[i]) begin
            state_next.cmp_flag[i] = 1'b0;
         end
         if (match[i]) begin
            state_next.cmp_flag[i] = 1'b1;
         end

         // latch follows the channel logic; mode changes leave it alone
         if (ce) begin
            state_next.latch[i] = latch_next[i];
         end
      end

      // clock enable low freezes everything
      if (!ce) begin
         state_next = state_reg;
      end
   end

   // state register with synchronous reset
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_reg.cnt <= CNT_BOTTOM;
         state_reg.cmp <= {NUM_CH{CMP_RESET}};
         state_reg.cmp_buf <= {NUM_CH{CMP_RESET}};
         state_reg.cmp_flag <= {NUM_CH{FLAG_RESET}};
         state_reg.latch <= {NUM_CH{LATCH_RESET}};
         state_reg.ovf <= FLAG_RESET;
         state_reg.blk <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // read back straight from the state flip-flops
   assign count_value = state_reg.cnt;
   assign compare_value_a = state_reg.cmp[CH_A];
   assign compare_value_b = state_reg.cmp[CH_B];
   assign compare_buffer_a = state_reg.cmp_buf[CH_A];
   assign compare_buffer_b = state_reg.cmp_buf[CH_B];
   assign overflow_flag = state_reg.ovf;
   assign compare_flag_a = state_reg.cmp_flag[CH_A];
   assign compare_flag_b = state_reg.cmp_flag[CH_B];
   assign compare_output_latch_a = state_reg.latch[CH_A];
   assign compare_output_latch_b = state_reg.latch[CH_B];

   // pins: latch or port value, direction from the port bit
   assign pin_out_a = pin_out[CH_A];
   assign pin_out_b = pin_out[CH_B];
   assign pin_oe_n_a = pin_oe_n[CH_A];
   assign pin_oe_n_b = pin_oe_n[CH_B];
endmodule : tc8_timer
`default_nettype wire

/* File: rtl/tc8_pkg.sv */
// constants and state type for the 8-bit timer compare/output block
// Contract
// - a counter write blocks every compare match for the next timer tick
// - writing the counter equal to a compare value loses that match
// - output latches keep their value across waveform mode changes
// - new output action applies from the first match after the write
// - force strobe in non-PWM modes applies the action to the latch at once
// - reset clears every output latch to 0
// - nonzero output action puts the latch on the pin instead of port value
// - pin direction stays with the direction bit during override
// - output action 0 leaves the latch unchanged on matches
// - only the waveform mode steers counting, never the output action
// - mode 0 counts up only and wraps 0xFF to 0x00
// - mode 0 overflow flag sets in the tick the counter becomes zero
// - mode 2 clears the counter on a match with compare value A
// - in mode 2 a compare A below the count means counting through 0xFF
// - in mode 2 compare flag A sets each time top is reached
// - in mode 2 action 1 toggles latch A on every match
// - in mode 2 overflow flag sets on the roll from 0xFF to 0x00
// - modes 3 and 7 count bottom to top; top 0xFF or compare value A
// - fast PWM non-inverting clears on match, sets at bottom; inverting opposite
// - an equality sets the compare flag at the next timer tick
// - a forced compare touches only the latch, not flag or counter
// - compare values are double buffered only in PWM modes
// - in fast PWM the counter clears at the tick after matching top
package tc8_pkg;
   localparam int NUM_CH = 2;
   localparam int CH_A = 0;
   localparam int CH_B = 1;
   localparam int CNT_W = 8;
   // waveform mode encodings
   localparam logic [2:0] MODE_NORMAL = 3'h0;
   localparam logic [2:0] MODE_CTC = 3'h2;
   localparam logic [2:0] MODE_FPWM_MAX = 3'h3;
   localparam logic [2:0] MODE_FPWM_CMPA = 3'h7;
   // counter extremes
   localparam logic [7:0] CNT_MAX = 8'hff;
   localparam logic [7:0] CNT_BOTTOM = 8'h00;
   localparam logic [7:0] CNT_ONE = 8'h01;
   // output action encodings
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;
   // reset values
   localparam logic [7:0] CMP_RESET = 8'h00;
   localparam logic LATCH_RESET = 1'b0;
   localparam logic FLAG_RESET = 1'b0;

   // whole state of the timer
   typedef struct packed {
      logic [7:0] cnt;
      logic [NUM_CH-1:0][7:0] cmp;
      logic [NUM_CH-1:0][7:0] cmp_buf;
      logic [NUM_CH-1:0] cmp_flag;
      logic [NUM_CH-1:0] latch;
      logic ovf;
      logic blk;
   } tc8_state_t;
endpackage : tc8_pkg

/* File: rtl/tc8_out_chan.sv */
// one compare channel: next output latch value and port pin override
`timescale 1ns/10ps
`default_nettype none
module tc8_out_chan
   import tc8_pkg::*;
(
   input wire logic [1:0] action,
   input wire logic pwm,
   input wire logic toggle_ok,
   input wire logic match,
   input wire logic bottom,
   input wire logic force_cmp,
   input wire logic latch,
   input wire logic port_value,
   input wire logic dir_out,
   output logic latch_next,
   output logic pin_out,
   output logic pin_oe_n
);
   // latch update; bottom wins over a match in the same tick so that a
   // compare value at top gives a steady level instead of a glitch
   always_comb begin
      latch_next = latch;
      if (pwm) begin
         // toggle falls through to the match, so a match at top a still toggles
         if (bottom && (action == ACT_CLEAR || action == ACT_SET)) begin
            latch_next = (action == ACT_CLEAR);
         end else if (match) begin
            unique case (action)
               ACT_NONE: latch_next = latch;
               ACT_TOGGLE: latch_next = toggle_ok ? ~latch : latch;
               ACT_CLEAR: latch_next = 1'b0;
               ACT_SET: latch_next = 1'b1;
            endcase
         end
      end else if (match || force_cmp) begin
         unique case (action)
            ACT_NONE: latch_next = latch;
            ACT_TOGGLE: latch_next = ~latch;
            ACT_CLEAR: latch_next = 1'b0;
            ACT_SET: latch_next = 1'b1;
         endcase
      end
   end

   // override does not depend on mode; direction stays with the port bit
   assign pin_out = (action != ACT_NONE) ? latch : port_value;
   assign pin_oe_n = ~dir_out;
endmodule : tc8_out_chan
`default_nettype wire

/* File: verification/tc8_pin_model.sv */
// port pin partner: pad level seen outside the block
`timescale 1ns/10ps
`default_nettype none
module tc8_pin_model (
   input wire logic pin_out,
   input wire logic pin_oe_n,
   output logic pad
);
   // pull-up holds the pad high while the pin is an input
   assign pad = pin_oe_n ? 1'b1 : pin_out;
endmodule : tc8_pin_model
`default_nettype wire

/* File: verification/tc8_timer_monitor.sv */
// concurrent checks on the timer block ports
`timescale 1ns/10ps
`default_nettype none
module tc8_timer_monitor
   import tc8_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic timer_tick,
   input wire logic [2:0] waveform_mode_select,
   input wire logic [1:0] output_action_select_a,
   input wire logic count_wr,
   input wire logic force_compare_strobe_a,
   input wire logic compare_flag_a_clear,
   input wire logic port_value_a,
   input wire logic pin_direction_bit_a,
   input wire logic [7:0] count_value,
   input wire logic [7:0] compare_value_a,
   input wire logic [7:0] compare_value_b,
   input wire logic overflow_flag,
   input wire logic compare_flag_a,
   input wire logic compare_flag_b,
   input wire logic compare_output_latch_a,
   input wire logic pin_out_a,
   input wire logic pin_oe_n_a
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic blk_reg, blk_next, step, wr, hit_a, hit_b;
   // qualified events; a write beats a tick
   assign step = ce && timer_tick;
   assign wr = ce && count_wr;
   assign hit_a = step && !wr && !blk_reg && count_value == compare_value_a;
   assign hit_b = step && !wr && !blk_reg && count_value == compare_value_b;
   // blocking window from a write until the next tick
   always_comb begin
      blk_next = wr ? 1'b1 : (step ? 1'b0 : blk_reg);
   end
   always_ff @(posedge ref_clk) begin
      blk_reg <= rst ? 1'b0 : blk_next;
   end
   sequence s_top_a;
      count_value == CNT_BOTTOM && compare_flag_a;
   endsequence
   sequence s_bottom_set;
      count_value == CNT_BOTTOM ##0 compare_output_latch_a;
   endsequence
   property p_ovf_wrap;
      step && !wr && waveform_mode_select == MODE_NORMAL && count_value == CNT_MAX
         |=> count_value == CNT_BOTTOM && overflow_flag;
   endproperty
   a_ovf_wrap: assert property (p_ovf_wrap) else $error("wrap or overflow wrong");
   property p_count_up;
      step && !wr && waveform_mode_select == MODE_NORMAL
         |=> count_value == $past(count_value) + CNT_ONE;
   endproperty
   a_count_up: assert property (p_count_up) else $error("count step wrong");
   property p_freeze;
      !step && !wr |=> $stable(count_value);
   endproperty
   a_freeze: assert property (p_freeze) else $error("count moved off tick");
   property p_ctc_top;
      waveform_mode_select == MODE_CTC && hit_a |=> s_top_a;
   endproperty
   a_ctc_top: assert property (p_ctc_top) else $error("top clear wrong");
   property p_blocked;
      waveform_mode_select == MODE_CTC && step && !wr && blk_reg
         && count_value == compare_value_a && count_value != CNT_MAX
         |=> count_value == $past(count_value) + CNT_ONE;
   endproperty
   a_blocked: assert property (p_blocked) else $error("blocked match acted");
   property p_flag_b;
      hit_b |=> compare_flag_b;
   endproperty
   a_flag_b: assert property (p_flag_b) else $error("flag b late");
   property p_toggle;
      waveform_mode_select == MODE_CTC && hit_a && output_action_select_a == ACT_TOGGLE
         && !force_compare_strobe_a |=> compare_output_latch_a != $past(compare_output_latch_a);
   endproperty
   a_toggle: assert property (p_toggle) else $error("no toggle");
   property p_keep;
      output_action_select_a == ACT_NONE |=> $stable(compare_output_latch_a);
   endproperty
   a_keep: assert property (p_keep) else $error("latch moved");
   property p_pin;
      pin_oe_n_a == !pin_direction_bit_a && pin_out_a ==
         (output_action_select_a != ACT_NONE ? compare_output_latch_a : port_value_a);
   endproperty
   a_pin: assert property (p_pin) else $error("pin override wrong");
   property p_fpwm_bottom;
      waveform_mode_select == MODE_FPWM_MAX && step && !wr && count_value == CNT_MAX
         && output_action_select_a == ACT_CLEAR |=> s_bottom_set;
   endproperty
   a_fpwm_bottom: assert property (p_fpwm_bottom) else $error("bottom wrong");
   property p_force;
      ce && force_compare_strobe_a && !timer_tick && !count_wr && !compare_flag_a_clear
         && waveform_mode_select == MODE_NORMAL && output_action_select_a == ACT_SET
         |=> compare_output_latch_a && $stable(compare_flag_a) && $stable(count_value);
   endproperty
   a_force: assert property (p_force) else $error("force wrong");
endmodule : tc8_timer_monitor
bind tc8_timer tc8_timer_monitor tc8_timer_monitor_i (.ref_clk, .rst, .ce, .timer_tick,
   .waveform_mode_select, .output_action_select_a, .count_wr, .force_compare_strobe_a,
   .compare_flag_a_clear, .port_value_a, .pin_direction_bit_a, .count_value, .compare_value_a,
   .compare_value_b, .overflow_flag, .compare_flag_a, .compare_flag_b, .compare_output_latch_a,
   .pin_out_a, .pin_oe_n_a);
`default_nettype wire

/* File: verification/tc8_timer_bench.sv */
// self-checking bench for the timer compare block
`timescale 1ns/10ps
`default_nettype none
module tc8_timer_bench;
   import tc8_pkg::*;
   typedef struct {tc8_state_t s; logic [1:0] pad;} tc8_note_t;
   logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b0, tick = 1'b0, wr = 1'b0, clro = 1'b0;
   logic [2:0] mode = MODE_NORMAL;
   logic [7:0] wd = 8'h00;
   logic [1:0] act [2] = '{2'h0, 2'h0};
   logic [7:0] cwd [2] = '{8'h00, 8'h00};
   logic cw [2] = '{1'b0, 1'b0}, f [2] = '{1'b0, 1'b0}, clr [2] = '{1'b0, 1'b0};
   logic pv [2] = '{1'b0, 1'b0}, dir [2] = '{1'b0, 1'b0};
   logic [7:0] count_value, compare_value_a, compare_value_b, compare_buffer_a, compare_buffer_b;
   logic overflow_flag, compare_flag_a, compare_flag_b, compare_output_latch_a;
   logic compare_output_latch_b, pin_out_a, pin_oe_n_a, pin_out_b, pin_oe_n_b;
   logic [1:0] pad;
   logic [2:0] ph [6] = '{MODE_NORMAL, MODE_CTC, MODE_FPWM_MAX, MODE_CTC, MODE_FPWM_CMPA, MODE_CTC};
   tc8_state_t m = '0;
   tc8_note_t q [$], cur;
   int err_total = 0, samples_checked = 0;
   tc8_timer tc8_timer_i (.ref_clk, .rst, .ce, .timer_tick(tick), .waveform_mode_select(mode),
      .output_action_select_a(act[0]), .output_action_select_b(act[1]), .count_wr(wr),
      .count_wdata(wd), .compare_a_wr(cw[0]), .compare_a_wdata(cwd[0]), .compare_b_wr(cw[1]),
      .compare_b_wdata(cwd[1]), .force_compare_strobe_a(f[0]), .force_compare_strobe_b(f[1]),
      .overflow_flag_clear(clro), .compare_flag_a_clear(clr[0]), .compare_flag_b_clear(clr[1]),
      .port_value_a(pv[0]), .port_value_b(pv[1]), .pin_direction_bit_a(dir[0]),
      .pin_direction_bit_b(dir[1]), .count_value, .compare_value_a, .compare_value_b,
      .compare_buffer_a, .compare_buffer_b, .overflow_flag, .compare_flag_a, .compare_flag_b,
      .compare_output_latch_a, .compare_output_latch_b, .pin_out_a, .pin_oe_n_a, .pin_out_b,
      .pin_oe_n_b);
   tc8_pin_model pin_a_i (.pin_out(pin_out_a), .pin_oe_n(pin_oe_n_a), .pad(pad[0]));
   tc8_pin_model pin_b_i (.pin_out(pin_out_b), .pin_oe_n(pin_oe_n_b), .pad(pad[1]));
   // 40 MHz system clock
   always #12.5 ref_clk = ~ref_clk;
   // reference model: state after the edge just taken
   task automatic upd();
      tc8_state_t n;
      logic pwm, hit, at_top;
      logic [7:0] top;
      n = m;
      pwm = mode == MODE_FPWM_MAX || mode == MODE_FPWM_CMPA;
      top = mode == MODE_FPWM_CMPA ? m.cmp[CH_A] : CNT_MAX;
      at_top = pwm && tick && m.cnt == top;
      if (rst) begin
         n = '0;
      end else if (ce) begin
         n.blk = wr || (m.blk && !tick);
         n.ovf = (tick && m.cnt == (pwm ? top : CNT_MAX)) || (m.ovf && !clro);
         if (wr) begin
            n.cnt = wd;
         end else if (tick) begin
            n.cnt = (pwm ? at_top : mode == MODE_CTC && m.cnt == m.cmp[CH_A] && !m.blk)
               ? CNT_BOTTOM : m.cnt + CNT_ONE;
         end
         if (at_top) n.cmp = m.cmp_buf;
         for (int c = 0; c < NUM_CH; c++) begin
            hit = tick && !m.blk && m.cnt == m.cmp[c];
            n.cmp_flag[c] = hit || (m.cmp_flag[c] && !clr[c]);
            if (at_top && act[c] >= ACT_CLEAR) begin
               n.latch[c] = act[c] == ACT_CLEAR;
            end else if (hit || (f[c] && !pwm)) begin
               // pwm toggle only for channel a with top a
               if (act[c] == ACT_TOGGLE) begin
                  if (!pwm || (c == CH_A && mode == MODE_FPWM_CMPA)) begin
                     n.latch[c] = !m.latch[c];
                  end
               end else if (act[c] != ACT_NONE) n.latch[c] = act[c] == ACT_SET;
            end
            if (cw[c]) n.cmp_buf[c] = cwd[c];
            if (cw[c] && !pwm) n.cmp[c] = cwd[c];
         end
      end
      m = n;
   endtask : upd
   // random inputs just after the edge; no counter writes while in pwm
   task automatic go(input bit pwp, input bit r);
      @(posedge ref_clk);
      #1;
      upd();
      rst = r;
      ce = ($urandom % 8) != 0;
      wr = !pwp && ($urandom % 12) == 0;
      tick = !wr && ($urandom % 3) != 0;
      wd = ($urandom % 2) ? m.cmp[CH_A] : 8'($urandom % 20);
      clro = ($urandom % 8) == 0;
      for (int c = 0; c < NUM_CH; c++) begin
         cw[c] = ($urandom % 10) == 0 && !(pwp && tick);
         cwd[c] = 8'($urandom % 16);
         f[c] = !tick && ($urandom % 10) == 0;
         clr[c] = ($urandom % 8) == 0;
         pv[c] = 1'($urandom);
         dir[c] = 1'($urandom);
         if (($urandom % 16) == 0) act[c] = pwp ? 2'(1 + $urandom % 3) : 2'($urandom);
      end
   endtask : go
   // expected state and pad levels for the checker process
   task automatic note();
      tc8_note_t e;
      e.s = m;
      for (int c = 0; c < NUM_CH; c++) begin
         e.pad[c] = dir[c] ? (act[c] != ACT_NONE ? m.latch[c] : pv[c]) : 1'b1;
      end
      q.push_back(e);
   endtask : note
   task automatic run(input int n, input bit pwp);
      repeat (n) begin
         go(pwp, 1'b0);
         note();
      end
   endtask : run
   task automatic chk_state(input tc8_state_t x);
      tc8_state_t o;
      o = x; // internal block bit is not visible
      o.cnt = count_value;
      o.cmp = {compare_value_b, compare_value_a};
      o.cmp_buf = {compare_buffer_b, compare_buffer_a};
      o.cmp_flag = {compare_flag_b, compare_flag_a};
      o.latch = {compare_output_latch_b, compare_output_latch_a};
      o.ovf = overflow_flag;
      samples_checked++;
      if (o !== x) begin
         err_total++;
         $display("MISMATCH %0t state exp %h got %h", $time, x, o);
      end
   endtask : chk_state
   task automatic chk_pad(input logic [1:0] x);
      samples_checked++;
      if (pad !== x) begin
         err_total++;
         $display("MISMATCH %0t pad exp %b got %b", $time, x, pad);
      end
   endtask : chk_pad
   task automatic final_report();
      if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report
   // checker: oldest note against the settled outputs
   always @(posedge ref_clk) begin
      #23;
      if (q.size() > 0) begin
         cur = q.pop_front();
         chk_state(cur.s);
         chk_pad(cur.pad);
      end
   end
   // watchdog: about five times the expected run
   initial begin
      #(25 * 20000);
      err_total++;
      final_report();
   end
   // reset, then random phases per mode; mode changes keep latches
   initial begin
      void'($urandom(32'h0b82));
      repeat (7) begin
         go(1'b0, 1'b1);
         note();
      end
      for (int i = 0; i < 6; i++) begin
         if (i == 3) begin
            go(1'b0, 1'b1);
            note();
         end
         if (ph[i] == MODE_FPWM_MAX || ph[i] == MODE_FPWM_CMPA) begin
            // counter to bottom and block window spent before pwm entry;
            // fixed cycles, so no input is driven twice in one time step
            @(posedge ref_clk);
            #1;
            upd();
            ce = 1'b1;
            mode = MODE_NORMAL;
            wr = 1'b1;
            tick = 1'b0;
            wd = 8'h00;
            cw[CH_A] = 1'b1;
            cwd[CH_A] = 8'h06;
            note();
            @(posedge ref_clk);
            #1;
            upd();
            wr = 1'b0;
            tick = 1'b1;
            cw[CH_A] = 1'b0;
            act[0] = ACT_CLEAR;
            act[1] = ACT_SET;
            note();
            go(1'b1, 1'b0);
         end else begin
            go(1'b0, 1'b0);
         end
         mode = ph[i];
         note();
         run(600, ph[i] == MODE_FPWM_MAX || ph[i] == MODE_FPWM_CMPA);
      end
      final_report();
   end
endmodule : tc8_timer_bench
`default_nettype wire
